/* hdl/port_ab_mux_pkg.sv */
// shared constants for the port a/b alternate function override logic
package port_ab_mux_pkg;

  localparam int PORT_WIDTH = 8;

  // port b pin positions of the alternate functions
  localparam int SCK_BIT = 7;
  localparam int MISO_BIT = 6;
  localparam int MOSI_BIT = 5;
  localparam int SLAVE_SEL_BIT = 4;
  localparam int CMP_B_BIT = 4;
  localparam int CMP_A_BIT = 3;
  localparam int COMP_NEG_BIT = 3;
  localparam int COMP_POS_BIT = 2;
  localparam int EXT_IRQ2_BIT = 2;
  localparam int CLK_OUT_BIT = 1;
  localparam int TMR1_CNT_BIT = 1;
  localparam int TMR0_CNT_BIT = 0;
  localparam int USART_CLK_BIT = 0;

  // change source numbering: port a is 7..0, port b is 15..8
  localparam int CHANGE_A_BASE = 0;
  localparam int CHANGE_B_BASE = 8;
  localparam int CHANGE_SRC_WIDTH = 16;

  // pad drive value loaded during reset, and all-zero/all-one fills
  localparam logic [7:0] PAD_RESET = 8'h00;
  localparam logic [7:0] ALL_ZERO = 8'h00;
  localparam logic [7:0] ALL_ONE = 8'hFF;

  // spi operating mode seen by the override logic
  typedef enum logic [1:0] {
    SPI_OFF = 2'b00,
    SPI_SLAVE = 2'b01,
    SPI_MASTER = 2'b10
  } spi_mode_t;

  // digital input seen by an alternate function, gated by its enable
  function automatic logic [7:0] gate_input(input logic [7:0] pad, input logic [7:0] en);
    gate_input = pad & en;
  endfunction : gate_input

endpackage : port_ab_mux_pkg

/* hdl/pin_override_resolve.sv */
// per-pin resolution of override signals against ordinary port control
`timescale 1ns/1ps
`default_nettype none
module pin_override_resolve #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] dirBits,
  input wire logic [WIDTH-1:0] outBits,
  input wire logic pullupDisable,
  input wire logic sleepDinDisable,
  input wire logic [WIDTH-1:0] pullupOverrideEn,
  input wire logic [WIDTH-1:0] pullupOverrideVal,
  input wire logic [WIDTH-1:0] dirOverrideEn,
  input wire logic [WIDTH-1:0] dirOverrideVal,
  input wire logic [WIDTH-1:0] outvalOverrideEn,
  input wire logic [WIDTH-1:0] outvalOverrideVal,
  input wire logic [WIDTH-1:0] dinEnableOverrideEn,
  input wire logic [WIDTH-1:0] dinEnableOverrideVal,
  output logic [WIDTH-1:0] pullupOn,
  output logic [WIDTH-1:0] driverOn,
  output logic [WIDTH-1:0] driveVal,
  output logic [WIDTH-1:0] dinEnable
);

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      // pullup only for an input pin with a high port bit and pullups allowed
      pullupOn[i] = pullupOverrideEn[i] ? pullupOverrideVal[i]
                                        : (!dirBits[i] && outBits[i] && !pullupDisable);
      driverOn[i] = dirOverrideEn[i] ? dirOverrideVal[i] : dirBits[i];
      // value only matters while the driver is on
      driveVal[i] = outvalOverrideEn[i] ? outvalOverrideVal[i] : outBits[i];
      dinEnable[i] = dinEnableOverrideEn[i] ? dinEnableOverrideVal[i] : !sleepDinDisable;
    end
  end

endmodule : pin_override_resolve
`default_nettype wire

/* hdl/port_ab_alternate_function_mux.sv */
// port a/b alternate function override logic between peripherals and pads
`timescale 1ns/1ps
`default_nettype none

module port_ab_alternate_function_mux
  import port_ab_mux_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] portaDirBits,
  input wire logic [WIDTH-1:0] portaOutBits,
  input wire logic [WIDTH-1:0] portbDirBits,
  input wire logic [WIDTH-1:0] portbOutBits,
  input wire logic pullupDisable,
  input wire logic sleepDinDisable,
  input wire logic [WIDTH-1:0] padAIn,
  input wire logic [WIDTH-1:0] padBIn,
  input wire logic [WIDTH-1:0] changeMaskGroup0,
  input wire logic changeGroup0Enable,
  input wire logic [WIDTH-1:0] changeMaskGroup1,
  input wire logic changeGroup1Enable,
  input wire logic [WIDTH-1:0] convDinDisable,
  input wire logic spiEnable,
  input wire logic spiMaster,
  input wire logic spiSckOut,
  input wire logic spiSlaveOut,
  input wire logic spiMasterOut,
  input wire logic tmr0CmpAEnable,
  input wire logic tmr0CmpAOut,
  input wire logic tmr0CmpBEnable,
  input wire logic tmr0CmpBOut,
  input wire logic extIrq2Enable,
  input wire logic clkOutFuse,
  input wire logic dividedClkOut,
  input wire logic usartSyncMode,
  input wire logic usartClkOut,
  output logic [WIDTH-1:0] padAOut,
  output logic [WIDTH-1:0] padAOe,
  output logic [WIDTH-1:0] padAPullup,
  output logic [WIDTH-1:0] padBOut,
  output logic [WIDTH-1:0] padBOe,
  output logic [WIDTH-1:0] padBPullup,
  output logic [WIDTH-1:0] padADinEn,
  output logic [WIDTH-1:0] padBDinEn,
  output logic [WIDTH-1:0] convChannelIn,
  output logic [CHANGE_SRC_WIDTH-1:0] changeSrc,
  output logic spiSckIn,
  output logic spiMasterIn,
  output logic spiSlaveIn,
  output logic spiSlaveSelected,
  output logic comparatorNegIn,
  output logic comparatorPosIn,
  output logic extIrq2,
  output logic tmr1CountIn,
  output logic tmr0CountIn,
  output logic usart0ExtClkIn
);

  spi_mode_t spiMode;
  logic spiSlave;
  logic spiMst;

  // port a override signals
  logic [WIDTH-1:0] aChangeOn;
  logic [WIDTH-1:0] aDinOvrEn;
  logic [WIDTH-1:0] aDinOvrVal;

  // port b override signals
  logic [WIDTH-1:0] bPullOvrEn;
  logic [WIDTH-1:0] bPullOvrVal;
  logic [WIDTH-1:0] bDirOvrEn;
  logic [WIDTH-1:0] bDirOvrVal;
  logic [WIDTH-1:0] bValOvrEn;
  logic [WIDTH-1:0] bValOvrVal;
  logic [WIDTH-1:0] bDinOvrEn;
  logic [WIDTH-1:0] bDinOvrVal;

  // resolved pin controls
  logic [WIDTH-1:0] aPull;
  logic [WIDTH-1:0] aDrv;
  logic [WIDTH-1:0] aVal;
  logic [WIDTH-1:0] aDinEn;
  logic [WIDTH-1:0] bPull;
  logic [WIDTH-1:0] bDrv;
  logic [WIDTH-1:0] bVal;
  logic [WIDTH-1:0] bDinEn;
  logic [WIDTH-1:0] aDin;
  logic [WIDTH-1:0] bDin;

  // registered pad drive
  logic [WIDTH-1:0] padAOut_reg;
  logic [WIDTH-1:0] padAOut_next;
  logic [WIDTH-1:0] padAOe_reg;
  logic [WIDTH-1:0] padAOe_next;
  logic [WIDTH-1:0] padAPullup_reg;
  logic [WIDTH-1:0] padAPullup_next;
  logic [WIDTH-1:0] padBOut_reg;
  logic [WIDTH-1:0] padBOut_next;
  logic [WIDTH-1:0] padBOe_reg;
  logic [WIDTH-1:0] padBOe_next;
  logic [WIDTH-1:0] padBPullup_reg;
  logic [WIDTH-1:0] padBPullup_next;

  always_comb begin
    if (!spiEnable) begin
      spiMode = SPI_OFF;
    end else if (spiMaster) begin
      spiMode = SPI_MASTER;
    end else begin
      spiMode = SPI_SLAVE;
    end
  end

  assign spiSlave = (spiMode == SPI_SLAVE);
  assign spiMst = (spiMode == SPI_MASTER);

  // port a: only the input enable is ever overridden
  always_comb begin
    aChangeOn = changeMaskGroup0 & {WIDTH{changeGroup0Enable}};
    aDinOvrEn = aChangeOn | convDinDisable;
    aDinOvrVal = aChangeOn;
  end

  // port b override table
  always_comb begin
    bPullOvrEn = ALL_ZERO;
    bPullOvrVal = ALL_ZERO;
    bDirOvrEn = ALL_ZERO;
    bDirOvrVal = ALL_ZERO;
    bValOvrEn = ALL_ZERO;
    bValOvrVal = ALL_ZERO;
    // serial clock: input as slave; as master the spi sets the value, the port bit the direction
    bDirOvrEn[SCK_BIT] = spiSlave;
    bValOvrEn[SCK_BIT] = spiMst;
    bValOvrVal[SCK_BIT] = spiSckOut;
    // master in / slave out
    bDirOvrEn[MISO_BIT] = spiMst;
    bValOvrEn[MISO_BIT] = spiSlave;
    bValOvrVal[MISO_BIT] = spiSlaveOut;
    // master out / slave in
    bDirOvrEn[MOSI_BIT] = spiSlave;
    bValOvrEn[MOSI_BIT] = spiMst;
    bValOvrVal[MOSI_BIT] = spiMasterOut;
    // slave select shares its pin with compare b
    bDirOvrEn[SLAVE_SEL_BIT] = spiSlave;
    bValOvrEn[CMP_B_BIT] = tmr0CmpBEnable;
    bValOvrVal[CMP_B_BIT] = tmr0CmpBOut;
    bValOvrEn[CMP_A_BIT] = tmr0CmpAEnable;
    bValOvrVal[CMP_A_BIT] = tmr0CmpAOut;
    // a forced spi input keeps its pullup under the port bit
    for (int i = SLAVE_SEL_BIT; i <= SCK_BIT; i++) begin
      bPullOvrEn[i] = bDirOvrEn[i];
      bPullOvrVal[i] = portbOutBits[i] & !pullupDisable;
    end
    // clock fuse wins over both port bits of pin 1
    bDirOvrEn[CLK_OUT_BIT] = clkOutFuse;
    bDirOvrVal[CLK_OUT_BIT] = clkOutFuse;
    bValOvrEn[CLK_OUT_BIT] = clkOutFuse;
    bValOvrVal[CLK_OUT_BIT] = dividedClkOut;
    // usart clock is an output only when the direction bit says so
    bValOvrEn[USART_CLK_BIT] = usartSyncMode & portbDirBits[USART_CLK_BIT];
    bValOvrVal[USART_CLK_BIT] = usartClkOut;
    bDinOvrEn = changeMaskGroup1 & {WIDTH{changeGroup1Enable}};
    bDinOvrEn[EXT_IRQ2_BIT] = bDinOvrEn[EXT_IRQ2_BIT] | extIrq2Enable;
    bDinOvrVal = ALL_ONE;
  end

  pin_override_resolve #(
    .WIDTH(WIDTH)
  ) u_resolve_a (
    .dirBits(portaDirBits),
    .outBits(portaOutBits),
    .pullupDisable(pullupDisable),
    .sleepDinDisable(sleepDinDisable),
    .pullupOverrideEn(ALL_ZERO),
    .pullupOverrideVal(ALL_ZERO),
    .dirOverrideEn(ALL_ZERO),
    .dirOverrideVal(ALL_ZERO),
    .outvalOverrideEn(ALL_ZERO),
    .outvalOverrideVal(ALL_ZERO),
    .dinEnableOverrideEn(aDinOvrEn),
    .dinEnableOverrideVal(aDinOvrVal),
    .pullupOn(aPull),
    .driverOn(aDrv),
    .driveVal(aVal),
    .dinEnable(aDinEn)
  );

  pin_override_resolve #(
    .WIDTH(WIDTH)
  ) u_resolve_b (
    .dirBits(portbDirBits),
    .outBits(portbOutBits),
    .pullupDisable(pullupDisable),
    .sleepDinDisable(sleepDinDisable),
    .pullupOverrideEn(bPullOvrEn),
    .pullupOverrideVal(bPullOvrVal),
    .dirOverrideEn(bDirOvrEn),
    .dirOverrideVal(bDirOvrVal),
    .outvalOverrideEn(bValOvrEn),
    .outvalOverrideVal(bValOvrVal),
    .dinEnableOverrideEn(bDinOvrEn),
    .dinEnableOverrideVal(bDinOvrVal),
    .pullupOn(bPull),
    .driverOn(bDrv),
    .driveVal(bVal),
    .dinEnable(bDinEn)
  );

  // inputs bypass any synchronizer; receivers that are not clocks sync themselves
  assign aDin = gate_input(padAIn, aDinEn);
  assign bDin = gate_input(padBIn, bDinEn);
  assign padADinEn = aDinEn;
  assign padBDinEn = bDinEn;

  // analog path ignores the digital input enable
  assign convChannelIn = padAIn;
  assign comparatorNegIn = padBIn[COMP_NEG_BIT];
  assign comparatorPosIn = padBIn[COMP_POS_BIT];

  assign changeSrc[CHANGE_A_BASE +: WIDTH] = aDin;
  assign changeSrc[CHANGE_B_BASE +: WIDTH] = bDin;

  assign spiSckIn = bDin[SCK_BIT];
  assign spiMasterIn = bDin[MISO_BIT];
  assign spiSlaveIn = bDin[MOSI_BIT];
  // select line low addresses this slave
  assign spiSlaveSelected = spiSlave & !padBIn[SLAVE_SEL_BIT];
  assign extIrq2 = bDin[EXT_IRQ2_BIT];
  assign tmr1CountIn = bDin[TMR1_CNT_BIT];
  assign tmr0CountIn = bDin[TMR0_CNT_BIT];
  assign usart0ExtClkIn = bDin[USART_CLK_BIT];

  always_comb begin
    if (sys_rst) begin
      // all pins float in reset, except the clock output pin
      padAOut_next = PAD_RESET;
      padAOe_next = PAD_RESET;
      padAPullup_next = PAD_RESET;
      padBOut_next = PAD_RESET;
      padBOe_next = PAD_RESET;
      padBPullup_next = PAD_RESET;
      padBOe_next[CLK_OUT_BIT] = clkOutFuse;
      padBOut_next[CLK_OUT_BIT] = clkOutFuse & dividedClkOut;
    end else begin
      padAOut_next = aVal;
      padAOe_next = aDrv;
      padAPullup_next = aPull;
      padBOut_next = bVal;
      padBOe_next = bDrv;
      padBPullup_next = bPull;
    end
  end

  // one cycle of latency on pad drive; a fast clock out sees it as delay only
  always_ff @(posedge core_clk) begin
    padAOut_reg <= padAOut_next;
    padAOe_reg <= padAOe_next;
    padAPullup_reg <= padAPullup_next;
    padBOut_reg <= padBOut_next;
    padBOe_reg <= padBOe_next;
    padBPullup_reg <= padBPullup_next;
  end

  assign padAOut = padAOut_reg;
  assign padAOe = padAOe_reg;
  assign padAPullup = padAPullup_reg;
  assign padBOut = padBOut_reg;
  assign padBOe = padBOe_reg;
  assign padBPullup = padBPullup_reg;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  property p_porta_plain;
    !$past(sys_rst) |-> (padAOe == $past(portaDirBits)) && (padAOut == $past(portaOutBits));
  endproperty
  a_porta_plain: assert property (p_porta_plain) else $error("port a drive overridden");
  property p_porta_din;
    padADinEn == ((changeMaskGroup0 & {WIDTH{changeGroup0Enable}})
                  | (~convDinDisable & {WIDTH{!sleepDinDisable}}));
  endproperty
  a_porta_din: assert property (p_porta_din) else $error("port a input enable wrong");
  property p_sck_slave;
    $past(spiEnable && !spiMaster) && !$past(sys_rst) |-> !padBOe[SCK_BIT];
  endproperty
  a_sck_slave: assert property (p_sck_slave) else $error("clock pin driven as slave");
  property p_sck_master;
    $past(spiEnable && spiMaster) && !$past(sys_rst)
      |-> padBOe[SCK_BIT] == $past(portbDirBits[SCK_BIT]);
  endproperty
  a_sck_master: assert property (p_sck_master) else $error("clock pin dir not from port");
  property p_forced_pullup;
    $past(spiEnable && !spiMaster) && !$past(sys_rst)
      |-> padBPullup[MOSI_BIT] == $past(portbOutBits[MOSI_BIT] && !pullupDisable);
  endproperty
  a_forced_pullup: assert property (p_forced_pullup) else $error("forced input pullup lost");
  property p_miso_master;
    $past(spiEnable && spiMaster) && !$past(sys_rst) |-> !padBOe[MISO_BIT];
  endproperty
  a_miso_master: assert property (p_miso_master) else $error("data-in pin driven as master");
  property p_slave_inputs;
    $past(spiEnable && !spiMaster) && !$past(sys_rst)
      |-> !padBOe[MOSI_BIT] && !padBOe[SLAVE_SEL_BIT];
  endproperty
  a_slave_inputs: assert property (p_slave_inputs) else $error("slave input pin driven");
  property p_cmp_b;
    $past(tmr0CmpBEnable) && !$past(sys_rst) |-> padBOut[CMP_B_BIT] == $past(tmr0CmpBOut);
  endproperty
  a_cmp_b: assert property (p_cmp_b) else $error("compare b not on pin");
  property p_clk_out;
    $past(clkOutFuse) |-> padBOe[CLK_OUT_BIT] && padBOut[CLK_OUT_BIT] == $past(dividedClkOut);
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("divided clock not driven");

  property p_clk_out_reset;
    @(posedge core_clk) disable iff (1'b0)
      $past(sys_rst && clkOutFuse)
        |-> padBOe[CLK_OUT_BIT] ##1 padBOe[CLK_OUT_BIT] || !$past(clkOutFuse);
  endproperty
  a_clk_out_reset: assert property (p_clk_out_reset) else $error("clock stopped in reset");

  property p_change_b;
    changeSrc[CHANGE_B_BASE +: WIDTH] == (padBIn & padBDinEn);
  endproperty
  a_change_b: assert property (p_change_b) else $error("port b change source wrong");

  property p_slave_sel;
    spiSlaveSelected |-> spiEnable && !spiMaster && !padBIn[SLAVE_SEL_BIT];
  endproperty
  a_slave_sel: assert property (p_slave_sel) else $error("slave active without select");

  c_slave_mode: cover property (spiEnable && !spiMaster ##1 spiSlaveSelected);
  c_master_mode: cover property (spiEnable && spiMaster && portbDirBits[SCK_BIT] ##1 padBOe[SCK_BIT]);
  c_clk_in_reset: cover property (@(posedge core_clk) disable iff (1'b0) sys_rst && clkOutFuse);
  c_change_a: cover property (changeGroup0Enable && |changeMaskGroup0);

endmodule : port_ab_alternate_function_mux
`default_nettype wire

/* test/pad_model.sv */
// behavioural pad and far-side driver model for one 8-bit port
`timescale 1ns/1ps
`default_nettype none
module pad_model (
  input wire logic core_clk,
  input wire logic [7:0] padOe,
  input wire logic [7:0] padOut,
  input wire logic [7:0] padPullup,
  input wire logic [7:0] extEn,
  input wire logic [7:0] extVal,
  output logic [7:0] padLevel
);
  logic [7:0] lastReg = 8'h00;

  // a floating line shows the inverse of its last level, so a stale value never passes
  always @(posedge core_clk) begin
    lastReg <= padLevel;
  end

  // the chip driver wins over the far side; contention is not modelled
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (padOe[b]) begin
        padLevel[b] = padOut[b];
      end else if (extEn[b]) begin
        padLevel[b] = extVal[b];
      end else if (padPullup[b]) begin
        padLevel[b] = 1'b1;
      end else begin
        padLevel[b] = ~lastReg[b];
      end
    end
  end
endmodule : pad_model
`default_nettype wire

/* test/tb_port_ab_alternate_function_mux.sv */
// self-checking bench for the port a/b alternate function mux
`timescale 1ns/1ps
`default_nettype none
module tb_port_ab_alternate_function_mux;
  import port_ab_mux_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, pullupDisable = 1'b0, sleepDinDisable = 1'b0;
  logic [7:0] portaDirBits = 8'h00, portaOutBits = 8'h00, portbDirBits = 8'h00;
  logic [7:0] portbOutBits = 8'h00, changeMaskGroup0 = 8'h00, changeMaskGroup1 = 8'h00;
  logic [7:0] convDinDisable = 8'h00, extEnA = 8'hFF, extValA = 8'h00;
  logic [7:0] extEnB = 8'hFF, extValB = 8'h00, padAIn, padBIn;
  logic changeGroup0Enable = 1'b0, changeGroup1Enable = 1'b0, spiEnable = 1'b0;
  logic spiMaster = 1'b0, spiSckOut = 1'b0, spiSlaveOut = 1'b0, spiMasterOut = 1'b0;
  logic tmr0CmpAEnable = 1'b0, tmr0CmpAOut = 1'b0, tmr0CmpBEnable = 1'b0, tmr0CmpBOut = 1'b0;
  logic extIrq2Enable = 1'b0, clkOutFuse = 1'b0, dividedClkOut = 1'b0;
  logic usartSyncMode = 1'b0, usartClkOut = 1'b0;
  logic [7:0] padAOut, padAOe, padAPullup, padBOut, padBOe, padBPullup;
  logic [7:0] padADinEn, padBDinEn, convChannelIn;
  logic [15:0] changeSrc;
  logic spiSckIn, spiMasterIn, spiSlaveIn, spiSlaveSelected, comparatorNegIn;
  logic comparatorPosIn, extIrq2, tmr1CountIn, tmr0CountIn, usart0ExtClkIn;
  int failCount = 0;
  int samplesChecked = 0;
  int cycles = 0;

  port_ab_alternate_function_mux uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .portaDirBits(portaDirBits),
    .portaOutBits(portaOutBits), .portbDirBits(portbDirBits), .portbOutBits(portbOutBits),
    .pullupDisable(pullupDisable), .sleepDinDisable(sleepDinDisable), .padAIn(padAIn),
    .padBIn(padBIn), .changeMaskGroup0(changeMaskGroup0), .changeGroup0Enable(changeGroup0Enable),
    .changeMaskGroup1(changeMaskGroup1), .changeGroup1Enable(changeGroup1Enable),
    .convDinDisable(convDinDisable), .spiEnable(spiEnable), .spiMaster(spiMaster),
    .spiSckOut(spiSckOut), .spiSlaveOut(spiSlaveOut), .spiMasterOut(spiMasterOut),
    .tmr0CmpAEnable(tmr0CmpAEnable), .tmr0CmpAOut(tmr0CmpAOut),
    .tmr0CmpBEnable(tmr0CmpBEnable), .tmr0CmpBOut(tmr0CmpBOut),
    .extIrq2Enable(extIrq2Enable), .clkOutFuse(clkOutFuse), .dividedClkOut(dividedClkOut),
    .usartSyncMode(usartSyncMode), .usartClkOut(usartClkOut), .padAOut(padAOut),
    .padAOe(padAOe), .padAPullup(padAPullup), .padBOut(padBOut), .padBOe(padBOe),
    .padBPullup(padBPullup), .padADinEn(padADinEn), .padBDinEn(padBDinEn),
    .convChannelIn(convChannelIn), .changeSrc(changeSrc), .spiSckIn(spiSckIn),
    .spiMasterIn(spiMasterIn), .spiSlaveIn(spiSlaveIn), .spiSlaveSelected(spiSlaveSelected),
    .comparatorNegIn(comparatorNegIn), .comparatorPosIn(comparatorPosIn), .extIrq2(extIrq2),
    .tmr1CountIn(tmr1CountIn), .tmr0CountIn(tmr0CountIn), .usart0ExtClkIn(usart0ExtClkIn)
  );

  pad_model padsA (
    .core_clk(core_clk), .padOe(padAOe), .padOut(padAOut), .padPullup(padAPullup),
    .extEn(extEnA), .extVal(extValA), .padLevel(padAIn)
  );

  pad_model padsB (
    .core_clk(core_clk), .padOe(padBOe), .padOut(padBOut), .padPullup(padBPullup),
    .extEn(extEnB), .extVal(extValB), .padLevel(padBIn)
  );

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // a hang counts as a mismatch
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failCount++;
      $display("wrong value at %0t: timeout", $time);
      finish_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // pad drive is registered, so look one full cycle after the change
  task automatic settle();
    @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle

  task automatic test_porta();
    logic [7:0] ovEn, ovVal, dinExp, lvl;
    for (int i = 0; i < 4; i++) begin
      changeGroup0Enable = i[0];
      sleepDinDisable = i[1];
      pullupDisable = i[0] ^ i[1];
      changeMaskGroup0 = 8'hA5;
      convDinDisable = 8'h3C;
      portaDirBits = 8'h0F;
      portaOutBits = 8'h33 ^ i[7:0];
      extValA = 8'h5A ^ (8'h11 * i[7:0]);
      settle();
      ovVal = changeMaskGroup0 & {8{changeGroup0Enable}};
      ovEn = ovVal | convDinDisable;
      dinExp = (ovEn & ovVal) | (~ovEn & {8{~sleepDinDisable}});
      lvl = (portaDirBits & portaOutBits) | (~portaDirBits & extValA);
      chk(padAOe, portaDirBits, "a oe");
      chk(padAOut & portaDirBits, portaOutBits & portaDirBits, "a out");
      chk(padAPullup, ~portaDirBits & portaOutBits & {8{~pullupDisable}}, "a pu");
      chk(padADinEn, dinExp, "a din");
      chk(convChannelIn, lvl, "conv");
      chk(changeSrc[7:0], lvl & dinExp, "chg a");
    end
    sleepDinDisable = 1'b0;
    pullupDisable = 1'b0;
    $display("test porta done");
  endtask : test_porta

  task automatic test_spi();
    logic [3:0] expOe, expOut;
    for (int m = 0; m < 3; m++) begin
      spiEnable = (m != 0);
      spiMaster = (m == 2);
      portbDirBits = 8'hFF;
      portbOutBits = 8'hD0;
      spiMasterOut = 1'b1;
      extEnB = 8'hF0;
      extValB = 8'hE0;
      settle();
      expOe = (m == 0) ? 4'hF : (m == 1) ? 4'h4 : 4'hB;
      expOut = (m == 0) ? 4'hD : (m == 1) ? 4'h9 : 4'h3;
      chk(padBOe[7:4], expOe, "spi oe");
      chk(padBOut[7:4] & expOe, expOut & expOe, "spi out");
      chk(padBPullup[7:4], ~expOe & 4'hD, "spi pu");
      if (m == 1) begin
        chk(spiSckIn, 1'b1, "sck in");
        chk(spiSlaveIn, 1'b1, "slave in");
        chk(spiSlaveSelected, 1'b1, "ss low");
        extValB[4] = 1'b1;
        #1;
        chk(spiSlaveSelected, 1'b0, "ss high");
        @(negedge core_clk);
      end
      if (m == 2) begin
        chk(spiMasterIn, 1'b1, "miso in");
        chk(spiSlaveSelected, 1'b0, "ss master");
      end
    end
    spiEnable = 1'b0;
    $display("test spi done");
  endtask : test_spi

  task automatic test_timer();
    for (int k = 0; k < 2; k++) begin
      tmr0CmpAEnable = 1'b1;
      tmr0CmpBEnable = 1'b1;
      tmr0CmpAOut = k[0];
      tmr0CmpBOut = ~k[0];
      portbOutBits = {3'h0, k[0], ~k[0], 3'h0};
      portbDirBits = 8'h18;
      settle();
      chk(padBOe[4:3], 2'h3, "cmp oe");
      chk(padBOut[4:3], {~k[0], k[0]}, "cmp out");
      portbDirBits = 8'h00;
      settle();
      chk(padBOe[4:3], 2'h0, "cmp off");
    end
    $display("test timer done");
  endtask : test_timer

  task automatic test_clkout();
    @(negedge core_clk);
    clkOutFuse = 1'b1;
    portbDirBits = 8'h00;
    portbOutBits = 8'h00;
    for (int j = 0; j < 6; j++) begin
      sys_rst = (j >= 2 && j < 4);
      dividedClkOut = j[0];
      settle();
      chk(padBOe[1], 1'b1, "clk oe");
      chk(padBOut[1], j[0], "clk out");
    end
    clkOutFuse = 1'b0;
    settle();
    chk(padBOe[1], 1'b0, "clk off");
    $display("test clkout done");
  endtask : test_clkout

  task automatic test_inputs();
    logic [7:0] v;
    extEnB = 8'hFF;
    // bit 2 stays enabled only through the irq enable, sleep default is off
    changeMaskGroup1 = 8'hFB;
    sleepDinDisable = 1'b1;
    changeGroup1Enable = 1'b1;
    extIrq2Enable = 1'b1;
    for (int k = 0; k < 2; k++) begin
      @(negedge core_clk);
      v = k[0] ? 8'hA5 : 8'h5A;
      extValB = v;
      usartSyncMode = 1'b1;
      usartClkOut = k[0];
      portbOutBits = {7'h00, ~k[0]};
      portbDirBits = 8'h01;
      // no clock edge passes before the look: inputs bypass any synchroniser
      #1;
      chk(changeSrc[15:8], v, "chg b");
      chk(comparatorNegIn, v[3], "neg");
      chk(comparatorPosIn, v[2], "pos");
      chk(extIrq2, v[2], "irq2");
      chk(tmr1CountIn, v[1], "t1");
      chk(tmr0CountIn, v[0], "t0");
      chk(usart0ExtClkIn, v[0], "xck in");
      settle();
      chk({padBOe[0], padBOut[0]}, {1'b1, k[0]}, "xck out");
      portbDirBits = 8'h00;
    end
    $display("test inputs done");
  endtask : test_inputs

  initial begin
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    test_porta();
    test_spi();
    test_timer();
    test_clkout();
    test_inputs();
    finish_test();
  end
endmodule : tb_port_ab_alternate_function_mux
`default_nettype wire
